// ===== exec_pkg.sv
// Constants, types and helpers shared by the instruction executor and its decoder.
// Assumes a 32-bit classic Wishbone register bus and one 20 MHz clock.
package exec_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] INSTR_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] WORK_OFS      = 8'h08;
    localparam logic [7:0] PC_OFS        = 8'h0C;
    localparam logic [7:0] LATCH_OFS     = 8'h10;
    localparam logic [7:0] WATCHDOG_OFS  = 8'h14;
    localparam logic [7:0] STACK_TOP_OFS = 8'h18;
    localparam logic [7:0] DATA_ADDR_OFS = 8'h1C;
    localparam logic [7:0] DATA_WIN_OFS  = 8'h20;

    // ------------------------------------------------------------
    // Status word field positions and reset values
    // ------------------------------------------------------------
    localparam int STAT_BUSY_POS    = 0;
    localparam int STAT_ZERO_POS    = 1;
    localparam int STAT_TO_POS      = 2;
    localparam int STAT_PD_POS      = 3;
    localparam int STAT_SKIP_POS    = 4;
    localparam int STAT_UNKNOWN_POS = 5;
    localparam int STAT_SP_POS      = 8;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [1:0]  LAST_QUARTER = 2'h3;
    localparam logic [3:0]  STACK_DEPTH_M1 = 4'hF;

    // ------------------------------------------------------------
    // Operation classes and executor states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE, bit_clear_op, bit_set_op, skip_if_bit_zero_op, skip_if_bit_one_op,
        bit_toggle_op, call_op, clear_location_op, watchdog_clear_op, complement_op,
        skip_if_equal_op, skip_if_greater_op
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DECODE, ST_READ, ST_PROCESS, ST_WRITE, ST_NOP
    } phase_e;

    // One-hot mask for a bit selector, used by several operations.
    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        bit_mask = 8'h01 << sel;
    endfunction : bit_mask

endpackage : exec_pkg

// ===== exec_if.sv
// Carrier between the executor core and its opcode decoder.
// Assumes both ends share one clock; the decoder is purely combinational.
`timescale 1ns/1ps
interface exec_if;
    logic [15:0]       opcode;
    exec_pkg::op_e     op;
    logic [2:0]        bit_sel;
    logic [7:0]        faddr;
    logic              dest_sel;
    logic [12:0]       literal;

    modport decoder (input opcode, output op, bit_sel, faddr, dest_sel, literal);
    modport core    (output opcode, input op, bit_sel, faddr, dest_sel, literal);
endinterface : exec_if

// ===== opcode_decoder.sv
// Opcode decoder: sorts a 16-bit instruction word into an operation class and fields.
// Assumes the core presents a stable opcode; outputs are combinational.
`timescale 1ns/1ps
module opcode_decoder (
    exec_if.decoder dec
);
    import exec_pkg::*;

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    assign dec.bit_sel  = dec.opcode[10:8];
    assign dec.faddr    = dec.opcode[7:0];
    assign dec.dest_sel = dec.opcode[8];
    assign dec.literal  = dec.opcode[12:0];

    // Pattern match on the upper opcode bits (the whole word for watchdog-clear); anything else is unknown.
    always_comb begin
        casez (dec.opcode)
            16'b1000_1???_????_????: dec.op = bit_clear_op;
            16'b1000_0???_????_????: dec.op = bit_set_op;
            16'b1001_1???_????_????: dec.op = skip_if_bit_zero_op;
            16'b1001_0???_????_????: dec.op = skip_if_bit_one_op;
            16'b0011_1???_????_????: dec.op = bit_toggle_op;
            16'b111?_????_????_????: dec.op = call_op;
            16'b0010_100?_????_????: dec.op = clear_location_op;
            16'b0000_0000_0000_0100: dec.op = watchdog_clear_op;
            16'b0001_001?_????_????: dec.op = complement_op;
            16'b0011_0001_????_????: dec.op = skip_if_equal_op;
            16'b0011_0010_????_????: dec.op = skip_if_greater_op;
            default:                 dec.op = OP_NONE;
        endcase
    end

endmodule : opcode_decoder

// ===== bit_ops_call_compare_exec.sv
// Executor for bit, call, clear, watchdog, complement and compare-skip instructions.
// Assumes a classic Wishbone master on clk_i and a synchronous active-high reset.
`timescale 1ns/1ps
// Behaviour
// - Bit-clear clears the selected bit of the addressed location in one cycle, no flags.
// - Bit-set sets the selected bit of the addressed location in one cycle, no flags.
// - Skip-if-bit-zero skips the next instruction when the selected bit reads zero.
// - Skip-if-bit-one skips the next instruction when the selected bit reads one.
// - A taken skip runs an idle cycle and then steps the PC one further, past the next instruction.
// - Bit-toggle inverts the selected bit only, with no flag change, in one cycle.
// - A short call pushes the next address, loads the 13-bit literal into the low PC bits, 2 cycles.
// - A short call loads literal bits 12..8 and PC bits 15..13 into the latch-high register.
// - Clear-location zeroes the location, and also the working register when s is 0.
// - Watchdog-clear zeroes the counter and postscaler and sets time-out and power-down flags.
// - Complement inverts the location into the working register or back, updating zero.
// - Skip-if-equal skips when location equals the working register, no flags.
// - Skip-if-greater skips when location is above the working register unsigned, no flags.
// - A taken skip-if-greater also costs an idle cycle, two cycles in all.
module bit_ops_call_compare_exec (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             busy_o
);
    import exec_pkg::*;

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    typedef struct packed {
        phase_e      st;
        logic [1:0]  q;
        logic [15:0] opcode;
        op_e         op;
        logic [7:0]  operand;
        logic        skip;
        logic        unknown;
        logic [7:0]  working_register;
        logic [15:0] pc;
        logic [7:0]  program_counter_latch_high;
        logic [3:0]  sp;
        logic        zero;
        logic        time_out_flag;
        logic        power_down_flag;
        logic [7:0]  watchdog_counter;
        logic [7:0]  watchdog_post;
        logic [7:0]  data_addr;
        logic        ack;
        logic [31:0] rdata;
    } state_s;

    state_s      s_reg;
    state_s      s_next;
    logic [7:0]  data_mem [256];
    logic [15:0] stack_mem [16];
    logic        mem_we;
    logic [7:0]  mem_wa;
    logic [7:0]  mem_wd;
    logic        push_we;
    logic [15:0] stack_top;
    logic [7:0]  mask;
    logic        bus_take;
    logic        bus_write;
    exec_if      dif ();

    opcode_decoder u_decoder (
        .dec (dif.decoder)
    );

    assign dif.opcode = s_reg.opcode;
    assign mask       = bit_mask(dif.bit_sel);
    assign stack_top  = stack_mem[s_reg.sp - 4'h1];
    assign bus_take   = wb_cyc_i && wb_stb_i && !s_reg.ack;
    assign bus_write  = wb_cyc_i && wb_stb_i && s_reg.ack && wb_we_i && wb_sel_i[0];

    // ------------------------------------------------------------
    // Data write port: quarter four of an operation, else an idle bus write.
    // ------------------------------------------------------------
    always_comb begin
        mem_we = 1'b0;
        mem_wa = dif.faddr;
        mem_wd = s_reg.operand;
        if (s_reg.st == ST_WRITE) begin
            unique case (s_reg.op)
                bit_clear_op: begin
                    mem_we = 1'b1;
                    mem_wd = s_reg.operand & ~mask;
                end
                bit_set_op: begin
                    mem_we = 1'b1;
                    mem_wd = s_reg.operand | mask;
                end
                bit_toggle_op: begin
                    mem_we = 1'b1;
                    mem_wd = s_reg.operand ^ mask;
                end
                clear_location_op: begin
                    mem_we = 1'b1;
                    mem_wd = BYTE_RESET;
                end
                complement_op: begin
                    mem_we = dif.dest_sel;
                    mem_wd = ~s_reg.operand;
                end
                default: mem_we = 1'b0;
            endcase
        end else if (s_reg.st == ST_IDLE && bus_write && wb_adr_i == DATA_WIN_OFS) begin
            mem_we = 1'b1;
            mem_wa = s_reg.data_addr;
            mem_wd = wb_dat_i[7:0];
        end
    end

    // The return address goes on the stack in the read quarter of a call.
    assign push_we = (s_reg.st == ST_READ) && (s_reg.op == call_op);

    // Memory arrays for the data locations and the hardware stack.
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            data_mem[mem_wa] <= mem_wd;
        end
        if (push_we) begin
            stack_mem[s_reg.sp] <= s_reg.pc + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic: quarter sequencing and register bus.
    // ------------------------------------------------------------
    always_comb begin
        s_next     = s_reg;
        s_next.ack = bus_take;
        unique case (s_reg.st)
            ST_IDLE: begin
                if (bus_write && wb_adr_i == INSTR_OFS) begin
                    s_next.opcode = wb_dat_i[15:0];
                    s_next.st     = ST_DECODE;
                end
            end
            ST_DECODE: begin
                s_next.op      = dif.op;
                s_next.unknown = (dif.op == OP_NONE);
                s_next.skip    = 1'b0;
                s_next.st      = ST_READ;
            end
            ST_READ: begin
                s_next.operand = data_mem[dif.faddr];
                s_next.st      = ST_PROCESS;
            end
            ST_PROCESS: begin
                unique case (s_reg.op)
                    skip_if_bit_zero_op: s_next.skip = (s_reg.operand & mask) == 8'h00;
                    skip_if_bit_one_op:  s_next.skip = (s_reg.operand & mask) != 8'h00;
                    skip_if_equal_op:    s_next.skip = s_reg.operand == s_reg.working_register;
                    skip_if_greater_op:  s_next.skip = s_reg.operand > s_reg.working_register;
                    default:             s_next.skip = 1'b0;
                endcase
                s_next.st = ST_WRITE;
            end
            ST_WRITE: begin
                s_next.st = ST_IDLE;
                s_next.pc = s_reg.pc + 16'h0001;
                unique case (s_reg.op)
                    call_op: begin
                        s_next.pc = {s_reg.pc[15:13], dif.literal};
                        s_next.program_counter_latch_high =
                            {s_reg.pc[15:13], dif.literal[12:8]};
                        s_next.sp = s_reg.sp + 4'h1;
                    end
                    clear_location_op: begin
                        if (!dif.dest_sel) begin
                            s_next.working_register = BYTE_RESET;
                        end
                    end
                    watchdog_clear_op: begin
                        s_next.watchdog_counter = BYTE_RESET;
                        s_next.watchdog_post    = BYTE_RESET;
                        s_next.time_out_flag    = 1'b1;
                        s_next.power_down_flag  = 1'b1;
                    end
                    complement_op: begin
                        s_next.zero = (~s_reg.operand) == 8'h00;
                        if (!dif.dest_sel) begin
                            s_next.working_register = ~s_reg.operand;
                        end
                    end
                    default: s_next.pc = s_reg.pc + 16'h0001;
                endcase
                if (s_reg.op != watchdog_clear_op) begin
                    {s_next.watchdog_post, s_next.watchdog_counter} =
                        {s_reg.watchdog_post, s_reg.watchdog_counter} + 16'h0001;
                    if (&{s_reg.watchdog_post, s_reg.watchdog_counter}) begin
                        s_next.time_out_flag = 1'b0;
                    end
                end
                if (s_reg.op == call_op || s_reg.skip) begin
                    s_next.st = ST_NOP;
                    s_next.q  = 2'h0;
                end
            end
            ST_NOP: begin
                s_next.q = s_reg.q + 2'h1;
                if (s_reg.q == LAST_QUARTER) begin
                    s_next.st = ST_IDLE;
                    if (s_reg.skip) begin
                        s_next.pc = s_reg.pc + 16'h0001;
                    end
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        // Bus writes to core registers are taken only while idle.
        if (s_reg.st == ST_IDLE && bus_write) begin
            unique case (wb_adr_i)
                WORK_OFS:      s_next.working_register = wb_dat_i[7:0];
                PC_OFS:        s_next.pc = wb_dat_i[15:0];
                LATCH_OFS:     s_next.program_counter_latch_high = wb_dat_i[7:0];
                DATA_ADDR_OFS: s_next.data_addr = wb_dat_i[7:0];
                default:       s_next.data_addr = s_reg.data_addr;
            endcase
        end
        // Read data is prepared in the cycle a request is taken.
        if (bus_take) begin
            unique case (wb_adr_i)
                INSTR_OFS:     s_next.rdata = {16'h0000, s_reg.opcode};
                STATUS_OFS:    s_next.rdata = {20'h00000, s_reg.sp, 2'h0, s_reg.unknown,
                                               s_reg.skip, s_reg.power_down_flag,
                                               s_reg.time_out_flag, s_reg.zero,
                                               s_reg.st != ST_IDLE};
                WORK_OFS:      s_next.rdata = {24'h000000, s_reg.working_register};
                PC_OFS:        s_next.rdata = {16'h0000, s_reg.pc};
                LATCH_OFS:     s_next.rdata = {24'h000000, s_reg.program_counter_latch_high};
                WATCHDOG_OFS:  s_next.rdata = {16'h0000, s_reg.watchdog_post,
                                               s_reg.watchdog_counter};
                STACK_TOP_OFS: s_next.rdata = {16'h0000, stack_top};
                DATA_ADDR_OFS: s_next.rdata = {24'h000000, s_reg.data_addr};
                DATA_WIN_OFS:  s_next.rdata = {24'h000000, data_mem[s_reg.data_addr]};
                default:       s_next.rdata = 32'h00000000;
            endcase
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg                 <= '0;
            s_reg.st              <= ST_IDLE;
            s_reg.op              <= OP_NONE;
            s_reg.pc              <= PC_RESET;
            s_reg.time_out_flag   <= 1'b1;
            s_reg.power_down_flag <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.rdata;
    assign busy_o   = s_reg.st != ST_IDLE;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence quarters_s;
        s_reg.st == ST_DECODE ##1 s_reg.st == ST_READ ##1 s_reg.st == ST_PROCESS
            ##1 s_reg.st == ST_WRITE;
    endsequence

    sequence idle_cycle_s;
        (s_reg.st == ST_NOP)[*4] ##1 s_reg.st == ST_IDLE;
    endsequence

    chk_clear_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_WRITE && s_reg.op == bit_clear_op
        |-> mem_we && mem_wd == (s_reg.operand & ~mask))
        else $error("bit clear wrote a wrong value");
    chk_set_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_WRITE && s_reg.op == bit_set_op
        |-> mem_we && mem_wd == (s_reg.operand | mask) && $stable(s_reg.zero))
        else $error("bit set wrote a wrong value");
    chk_toggle_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_WRITE && s_reg.op == bit_toggle_op
        |-> mem_we && (mem_wd ^ s_reg.operand) == mask)
        else $error("bit toggle changed the wrong bits");
    chk_skip_nop: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_WRITE && s_reg.skip |=> idle_cycle_s)
        else $error("taken skip did not run one idle cycle");
    chk_quarter_order: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_IDLE ##1 s_reg.st == ST_DECODE |-> ##1 s_reg.st == ST_READ
        ##1 s_reg.st == ST_PROCESS ##1 s_reg.st == ST_WRITE)
        else $error("quarters ran out of order");
    chk_skip_nowrite: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_WRITE && s_reg.op inside {skip_if_bit_zero_op, skip_if_bit_one_op,
        skip_if_equal_op, skip_if_greater_op} |-> !mem_we)
        else $error("skip operation wrote data");
    chk_compare_skip: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_PROCESS && s_reg.op == skip_if_greater_op
        |=> s_reg.skip == ($past(s_reg.operand) > s_reg.working_register))
        else $error("compare greater decided wrongly");
    chk_equal_skip: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_PROCESS && s_reg.op == skip_if_equal_op
        |=> s_reg.skip == ($past(s_reg.operand) == s_reg.working_register))
        else $error("compare equal decided wrongly");
    chk_call_target: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_WRITE && s_reg.op == call_op
        |=> (s_reg.pc[12:0] == $past(s_reg.opcode[12:0])
        && s_reg.program_counter_latch_high == {s_reg.pc[15:13], s_reg.opcode[12:8]})
        ##0 idle_cycle_s)
        else $error("call target or latch wrong");
    chk_wdt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        quarters_s ##0 s_reg.op == watchdog_clear_op
        |=> s_reg.watchdog_counter == 8'h00 && s_reg.watchdog_post == 8'h00
        && s_reg.time_out_flag && s_reg.power_down_flag)
        else $error("watchdog clear incomplete");
    chk_clear_work: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_WRITE && s_reg.op == clear_location_op && !dif.dest_sel
        |=> s_reg.working_register == 8'h00)
        else $error("clear did not zero working register");
    chk_complement_z: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == ST_WRITE && s_reg.op == complement_op
        |=> s_reg.zero == ($past(s_reg.operand) == 8'hFF))
        else $error("complement zero flag wrong");

endmodule : bit_ops_call_compare_exec

// ===== bit_ops_call_compare_exec_tb.sv
// Self-checking bench for the bit, call, compare and watchdog executor.
// Assumes the register map of exec_pkg and a one-cycle Wishbone answer.
`timescale 1ns/1ps
module bit_ops_call_compare_exec_tb;
    import exec_pkg::*;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    logic        wb_ack_o;
    logic        busy_o;
    int          error_cnt   = 0;
    int          check_count = 0;
    logic [15:0] pc_m;
    logic [12:0] k;
    logic [7:0]  f, v, w, r;
    logic [2:0]  b;
    logic        z_m, s;

    bit_ops_call_compare_exec DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));

    // The clock toggles every half period of 25 ns.
    always #25 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("mismatches %0d of %0d checks", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // Compares a value and counts any mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // Expected byte after a bit operation: kind 0 clears, 1 sets, 2 toggles the bit.
    function automatic logic [7:0] bit_expect(input int kind, input logic [7:0] val,
                                              input logic [2:0] sel);
        logic [7:0] msk;
        msk = 8'h01 << sel;
        bit_expect = (kind == 0) ? (val & ~msk) : (kind == 1) ? (val | msk) : (val ^ msk);
    endfunction : bit_expect

    // One classic cycle; the request holds until ack is sampled high.
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 20) begin
            error_cnt++;
            $display("unexpected at %0t: no bus answer", $time);
            conclude();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0, rd);
        chk(rd, exp, what);
    endtask : chk_rd

    // Runs one opcode; mode 0 is plain, 1 a taken skip, 2 a call.
    task automatic exec(input logic [15:0] op, input int mode);
        int n;
        bus(1'b1, INSTR_OFS, {16'h0, op}, rd);
        for (n = 0; n < 30; n++) begin
            @(posedge clk_i);
            if (busy_o !== 1'b1) break;
        end
        chk(32'(n), (mode > 0) ? 32'd8 : 32'd4, "busy cycles");
        if (n == 30) conclude();
        if (mode < 2) begin
            pc_m = pc_m + 16'(mode + 1);
            chk_rd(PC_OFS, {16'h0, pc_m}, "pc");
            bus(1'b0, STATUS_OFS, 32'h0, rd);
            chk({28'h0, rd[3:0]}, {28'h0, 2'b11, z_m, 1'b0}, "flags");
        end
    endtask : exec

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h6B32));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        pc_m = 16'h0000;
        z_m = 1'b0;
        chk_rd(STATUS_OFS, 32'h0000_000C, "reset status");
        chk_rd(8'h40, 32'h0, "unmapped");
        // Every operation class but call in turn on random locations and operands.
        for (int i = 0; i < 40; i++) begin
            f = 8'($urandom);
            v = (i == 16) ? 8'hFF : 8'($urandom);
            w = (i % 3 == 0) ? v : 8'($urandom);
            b = 3'($urandom);
            s = 1'($urandom);
            r = v;
            bus(1'b1, DATA_ADDR_OFS, {24'h0, f}, rd);
            bus(1'b1, DATA_WIN_OFS, {24'h0, v}, rd);
            bus(1'b1, WORK_OFS, {24'h0, w}, rd);
            case (i % 10)
                0: begin r = bit_expect(0, v, b); exec({5'b10001, b, f}, 0); end
                1: begin r = bit_expect(1, v, b); exec({5'b10000, b, f}, 0); end
                2: begin r = bit_expect(2, v, b); exec({5'b00111, b, f}, 0); end
                3: exec({5'b10011, b, f}, int'(v[b] == 1'b0));
                4: exec({5'b10010, b, f}, int'(v[b]));
                5: begin r = 8'h00; w = s ? w : 8'h00; exec({7'b0010100, s, f}, 0); end
                6: begin
                    if (s) r = ~v;
                    else w = ~v;
                    z_m = (v == 8'hFF);
                    exec({7'b0001001, s, f}, 0);
                end
                7: exec({8'h31, f}, int'(v == w));
                8: exec({8'h32, f}, int'(v > w));
                default: begin
                    exec(16'h0004, 0);
                    chk_rd(WATCHDOG_OFS, 32'h0, "watchdog");
                end
            endcase
            chk_rd(DATA_WIN_OFS, {24'h0, r}, "data");
            chk_rd(WORK_OFS, {24'h0, w}, "working");
        end
        $display("test operations done");
        // Calls from random pages stack up return addresses.
        for (int j = 0; j < 3; j++) begin
            pc_m = 16'($urandom);
            k = 13'($urandom);
            bus(1'b1, PC_OFS, {16'h0, pc_m}, rd);
            exec({3'b111, k}, 2);
            chk_rd(PC_OFS, {16'h0, pc_m[15:13], k}, "call pc");
            chk_rd(LATCH_OFS, {24'h0, pc_m[15:13], k[12:8]}, "latch");
            chk_rd(STACK_TOP_OFS, {16'h0, pc_m + 16'h1}, "stack top");
            bus(1'b0, STATUS_OFS, 32'h0, rd);
            chk({28'h0, rd[11:8]}, 32'(j + 1), "depth");
        end
        $display("test calls done");
        conclude();
    end
endmodule : bit_ops_call_compare_exec_tb
